/* wd_defines.svh */
// Offsets, field positions, reset values and timing counts of the watchdog.
`ifndef WD_DEFINES_SVH
`define WD_DEFINES_SVH

// Watchdog counter register in the core's data space.
`define WD_REG_OFFSET    8'hD8
`define WD_REG_RESET     8'hFE
`define WD_BIT_C         0
`define WD_BIT_SR        1
`define WD_PER_LSB       2
`define WD_PER_MSB       7
// Value that clears the software-reset bit while leaving the period long.
`define WD_SAFE_DISABLE  8'hFD

// Core clock cycles per decrement of the period count.
`define WD_PRESCALE      12'd3072
// Instructions that must retire before the count may run.
`define WD_GUARD_INSTR   5'd28
// Length of the chip reset, standing in for oscillator stabilisation.
`define WD_STAB_CYCLES   12'd2048

// Controller registers on the Avalon-MM slave (byte addresses).
`define WD_AV_CTRL       4'h0
`define WD_AV_CFG        4'h4
`define WD_AV_STAT       4'h8
// Control register bits.
`define WD_CTL_WRITE     0
`define WD_CTL_STOP      1
`define WD_CTL_INSTR     2
`define WD_CTL_IRQ       3
`define WD_CTL_NMI       4
`define WD_CTL_DATA_LSB  8
`define WD_CTL_DATA_MSB  15
// Configuration register bits.
`define WD_CFG_GEN       0
`define WD_CFG_NMI_PIN   1
`define WD_CFG_GUARD     2

`endif

/* wd_dev.sv */
// Digital watchdog with a reloadable downcounter.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "wd_defines.svh"

module wd_dev
    import wd_pkg::*;
#(
    parameter bit HW_ACT   = 1'b0,
    parameter bit EXT_STOP = 1'b0
) (
    // Clock and reset.
    input  wire logic   clk,
    input  wire logic   rstn,
    // Link to the core side.
    wd_link_if.dev      link,
    // User side.
    output logic        wd_active,
    output logic        wd_reset_out
);

    ////////////////////////////////////////////////////////////////////////
    // Bit order helpers.

    function automatic logic [5:0] rev6(input logic [5:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < 6; i++) begin
            r[i] = v[5 - i];
        end
        return r;
    endfunction

    // Register image to physical counter: bit 6 is the software-reset bit.
    function automatic logic [6:0] reg2cnt(input logic [7:0] r);
        return {r[`WD_BIT_SR], rev6(r[`WD_PER_MSB:`WD_PER_LSB])};
    endfunction

    function automatic logic [7:0] cnt2reg(input logic [6:0] c,
                                           input logic       act);
        return {rev6(c[5:0]), c[6], act};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State.

    logic [6:0]     cnt_r;
    logic           act_r;
    logic [11:0]    pre_r;
    logic [4:0]     guard_r;
    logic           rst_r;
    logic [11:0]    stab_r;
    wd_mode_t       mode_r;
    logic           nmi_s1_r;
    logic           nmi_s2_r;
    logic [7:0]     rdata_r;

    logic           wr_ok;
    logic           wr_sr_clear;
    logic           guard_ok;
    logic           cnt_en;
    logic           tick;
    logic           underflow;
    logic           rst_fire;
    logic           wake;

    always_comb begin
        wr_ok       = link.reg_wr && link.reg_wdata[`WD_BIT_SR];
        wr_sr_clear = link.reg_wr && !link.reg_wdata[`WD_BIT_SR];
        guard_ok    = (guard_r == `WD_GUARD_INSTR);
        // A stopped core freezes the count; the guard holds it after start.
        cnt_en      = (mode_r != WD_STOP) && (!act_r || guard_ok);
        tick        = cnt_en && (pre_r == `WD_PRESCALE - 12'd1);
        // Borrow out of the period bits is bit 6 falling.
        underflow   = tick && act_r && (cnt_r[5:0] == 6'h00);
        rst_fire    = !rst_r && (underflow || wr_sr_clear);
        // Wakes need interrupts enabled, the non-maskable one included.
        wake        = link.gen && (link.irq_req || link.nmi_req);
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser for the non-maskable interrupt line.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nmi_s1_r <= 1'b0;
            nmi_s2_r <= 1'b0;
        end else begin
            nmi_s1_r <= link.nmi_pin;
            nmi_s2_r <= nmi_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler: one decrement per fixed run of core cycles.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_r <= 12'd0;
        end else if (rst_r) begin
            pre_r <= 12'd0;
        end else if (tick) begin
            pre_r <= 12'd0;
        end else if (cnt_en) begin
            pre_r <= pre_r + 12'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Downcounter.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= reg2cnt(`WD_REG_RESET);
        end else if (rst_r) begin
            cnt_r <= reg2cnt(`WD_REG_RESET);
        end else if (wr_ok) begin
            cnt_r <= reg2cnt(link.reg_wdata);
        end else if (tick) begin
            // Inactive, all seven bits wrap as a plain timer.
            cnt_r <= cnt_r - 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Activation.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            act_r <= HW_ACT;
        end else if (rst_r) begin
            act_r <= HW_ACT;
        end else if (wr_ok && link.reg_wdata[`WD_BIT_C]) begin
            act_r <= 1'b1;
        end
        // A write with the control bit low never clears it.
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction guard after reset or activation.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            guard_r <= 5'd0;
        end else if (rst_r) begin
            guard_r <= 5'd0;
        end else if (wr_ok && link.reg_wdata[`WD_BIT_C] && !act_r) begin
            guard_r <= 5'd0;
        end else if (link.instr_done && !guard_ok) begin
            guard_r <= guard_r + 5'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chip reset with stabilisation delay.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_r  <= 1'b0;
            stab_r <= 12'd0;
        end else if (rst_fire) begin
            rst_r  <= 1'b1;
            stab_r <= `WD_STAB_CYCLES - 12'd1;
        end else if (rst_r) begin
            if (stab_r == 12'd0) begin
                rst_r <= 1'b0;
            end else begin
                stab_r <= stab_r - 12'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stop and wait handling.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= WD_RUN;
        end else if (rst_r) begin
            mode_r <= WD_RUN;
        end else begin
            case (mode_r)
                WD_RUN: begin
                    if (link.stop_instr) begin
                        if (!act_r) begin
                            mode_r <= WD_STOP;
                        end else if (EXT_STOP && nmi_s2_r) begin
                            mode_r <= WD_STOP;
                        end else begin
                            mode_r <= WD_WAIT;
                        end
                    end
                end
                WD_WAIT: begin
                    if (wake) begin
                        mode_r <= WD_RUN;
                    end
                end
                WD_STOP: begin
                    if (wake) begin
                        mode_r <= WD_RUN;
                    end
                end
                default: begin
                    mode_r <= WD_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read image.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= `WD_REG_RESET | {7'h00, HW_ACT};
        end else begin
            rdata_r <= cnt2reg(cnt_r, act_r || HW_ACT);
        end
    end

    assign link.reg_rdata = rdata_r;
    assign link.core_mode = mode_r;
    assign link.chip_rst  = rst_r;
    assign wd_active      = act_r;
    assign wd_reset_out   = rst_r;

endmodule

`default_nettype wire

/* wd_host.sv */
// Core-side controller that drives the watchdog for Avalon-MM software.
`timescale 1ns/1ns
`default_nettype none
`include "wd_defines.svh"

module wd_host
    import wd_pkg::*;
(
    // Clock and reset.
    input  wire logic           clk,
    input  wire logic           rstn,
    // Avalon-MM slave.
    input  wire logic [3:0]     avs_address,
    input  wire logic           avs_read,
    input  wire logic           avs_write,
    input  wire logic [31:0]    avs_writedata,
    output logic [31:0]         avs_readdata,
    output logic                avs_waitrequest,
    // Link to the watchdog.
    wd_link_if.host             link
);

    logic           wait_r;
    logic [31:0]    rdata_r;
    logic           wr_r;
    logic [7:0]     wdata_r;
    logic           stop_r;
    logic           instr_r;
    logic           irq_r;
    logic           nmi_r;
    logic [2:0]     cfg_r;
    logic           rst_d_r;
    logic           chk_r;
    logic [7:0]     rst_cnt_r;

    logic           wr_go;
    logic           ctl_go;

    always_comb begin
        wr_go  = avs_write && !wait_r;
        ctl_go = wr_go && (avs_address == `WD_AV_CTRL);
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: every access is taken one cycle after it appears.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= !((avs_read || avs_write) && wait_r);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h00000000;
        end else if (avs_read && wait_r) begin
            if (avs_address == `WD_AV_CFG) begin
                rdata_r <= {29'h00000000, cfg_r};
            end else if (avs_address == `WD_AV_STAT) begin
                rdata_r <= {8'h00, rst_cnt_r, 4'h0, link.chip_rst,
                            link.core_mode, link.reg_rdata};
            end else begin
                rdata_r <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Orders to the watchdog, one-cycle pulses.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_r    <= 1'b0;
            wdata_r <= `WD_REG_RESET;
            stop_r  <= 1'b0;
            instr_r <= 1'b0;
            irq_r   <= 1'b0;
            nmi_r   <= 1'b0;
        end else begin
            wr_r    <= 1'b0;
            stop_r  <= ctl_go && avs_writedata[`WD_CTL_STOP];
            instr_r <= ctl_go && avs_writedata[`WD_CTL_INSTR];
            irq_r   <= ctl_go && avs_writedata[`WD_CTL_IRQ];
            nmi_r   <= ctl_go && avs_writedata[`WD_CTL_NMI];
            if (chk_r && cfg_r[`WD_CFG_GUARD]
                    && link.reg_rdata[`WD_BIT_C]) begin
                wr_r    <= 1'b1;
                wdata_r <= `WD_SAFE_DISABLE;
            end else if (ctl_go && avs_writedata[`WD_CTL_WRITE]) begin
                wr_r    <= 1'b1;
                wdata_r <= avs_writedata[`WD_CTL_DATA_MSB:`WD_CTL_DATA_LSB];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration; the interrupt enable clears with every chip reset.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_r <= 3'b010;
        end else if (link.chip_rst) begin
            cfg_r[`WD_CFG_GEN] <= 1'b0;
        end else if (wr_go && avs_address == `WD_AV_CFG) begin
            cfg_r <= avs_writedata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chip reset tracking and the startup check after release.

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_d_r   <= 1'b0;
            chk_r     <= 1'b0;
            rst_cnt_r <= 8'h00;
        end else begin
            rst_d_r <= link.chip_rst;
            // One cycle after release, so the read image is settled.
            chk_r   <= rst_d_r && !link.chip_rst;
            if (link.chip_rst && !rst_d_r) begin
                rst_cnt_r <= rst_cnt_r + 8'h01;
            end
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata    = rdata_r;
    assign link.reg_wr     = wr_r;
    assign link.reg_wdata  = wdata_r;
    assign link.stop_instr = stop_r;
    assign link.instr_done = instr_r;
    assign link.irq_req    = irq_r;
    assign link.nmi_req    = nmi_r;
    assign link.gen        = cfg_r[`WD_CFG_GEN];
    assign link.nmi_pin    = cfg_r[`WD_CFG_NMI_PIN];

endmodule

`default_nettype wire

/* wd_link_if.sv */
// Link between the watchdog and the core-side controller.
`timescale 1ns/1ns
`default_nettype none

interface wd_link_if;
    import wd_pkg::*;

    logic           reg_wr;
    logic [7:0]     reg_wdata;
    logic [7:0]     reg_rdata;
    logic           stop_instr;
    logic           instr_done;
    logic           irq_req;
    logic           nmi_req;
    logic           gen;
    logic           nmi_pin;
    wd_mode_t       core_mode;
    logic           chip_rst;

    modport dev (
        input  reg_wr, reg_wdata, stop_instr, instr_done,
        input  irq_req, nmi_req, gen, nmi_pin,
        output reg_rdata, core_mode, chip_rst
    );

    modport host (
        output reg_wr, reg_wdata, stop_instr, instr_done,
        output irq_req, nmi_req, gen, nmi_pin,
        input  reg_rdata, core_mode, chip_rst
    );

endinterface

`default_nettype wire

/* wd_link_monitor.sv */
// Concurrent checks on the link between the watchdog and its controller.
`timescale 1ns/1ns
`default_nettype none

module wd_link_monitor
    import wd_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rstn,
    // Link signals.
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       stop_instr,
    input  wire logic       irq_req,
    input  wire logic       nmi_req,
    input  wire logic       gen,
    input  wire wd_mode_t   core_mode,
    input  wire logic       chip_rst
);

    localparam int STAB = 2048;

    logic [12:0] rst_cnt_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    // Length of the chip reset seen so far.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt_r <= 13'h0000;
        end else if (chip_rst) begin
            rst_cnt_r <= rst_cnt_r + 13'h0001;
        end else begin
            rst_cnt_r <= 13'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_set_c;
        reg_wr && reg_wdata[1:0] == 2'b11 && !chip_rst ##1 !chip_rst
            ##1 !chip_rst;
    endsequence

    sequence s_stop_idle;
        (core_mode == WD_STOP && !reg_wr && !chip_rst) [*3];
    endsequence

    a_sr_write_reset: assert property (
        reg_wr && !reg_wdata[1] && !chip_rst |=> chip_rst)
        else $error("clearing the software reset bit gave no reset");
    a_rst_length: assert property (
        $fell(chip_rst) |-> rst_cnt_r == STAB)
        else $error("chip reset ended at the wrong length");
    a_rst_bound: assert property (
        chip_rst |-> rst_cnt_r < STAB)
        else $error("chip reset stood too long");
    a_c_sticky: assert property (
        reg_rdata[0] && !chip_rst |=> reg_rdata[0] || chip_rst)
        else $error("watchdog left the active state without reset");
    a_c_set: assert property (
        s_set_c |-> reg_rdata[0])
        else $error("setting the control bit did not activate");
    a_stop_inactive: assert property (
        stop_instr && !reg_wr && !$past(reg_wr) && !reg_rdata[0]
            && core_mode == WD_RUN && !chip_rst |=> core_mode == WD_STOP)
        else $error("inactive stop did not enter stop");
    a_stop_active: assert property (
        stop_instr && reg_rdata[0] && core_mode == WD_RUN && !chip_rst
            |=> core_mode == WD_WAIT || chip_rst)
        else $error("active stop did not act as wait");
    a_no_wake_gen: assert property (
        core_mode != WD_RUN && !gen && !chip_rst ##1 !chip_rst
            |-> $stable(core_mode))
        else $error("core woke with interrupts disabled");
    a_wake_run: assert property (
        core_mode != WD_RUN && gen && (irq_req || nmi_req) |=>
            core_mode == WD_RUN)
        else $error("interrupt did not wake the core");
    a_stop_freeze: assert property (
        s_stop_idle |-> $stable(reg_rdata))
        else $error("count moved during stop");

endmodule

`default_nettype wire

/* wd_pkg.sv */
// Types shared by the watchdog and its controller.
package wd_pkg;

    // Power state of the core as steered by the watchdog.
    typedef enum logic [2:0] {
        WD_RUN  = 3'b001,
        WD_WAIT = 3'b010,
        WD_STOP = 3'b100
    } wd_mode_t;

endpackage

/* wd_tb.sv */
// Self-checking bench joining the watchdog and its controller.
`timescale 1ns/1ns
`default_nettype none
`include "wd_defines.svh"

module wd_tb;

    logic        clk;
    logic        rstn;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        wd_active;
    logic        wd_reset_out;
    logic [31:0] q;
    logic [31:0] avs_readdata2;
    logic [31:0] q2;
    int          n_fail;
    int          n_checks;
    int          k;
    int          i;

    wd_link_if wd_link_if_i ();

    wd_dev #(.HW_ACT(1'b0), .EXT_STOP(1'b0)) wd_dev_i (
        .clk(clk), .rstn(rstn), .link(wd_link_if_i),
        .wd_active(wd_active), .wd_reset_out(wd_reset_out));

    wd_host wd_host_i (
        .clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .link(wd_link_if_i));

    // Second pair with hardware activation and external stop control.
    // It shares the bus inputs and answers with the same timing.
    wd_link_if wd_link_if_hw_i ();

    wd_dev #(.HW_ACT(1'b1), .EXT_STOP(1'b1)) wd_dev_hw_i (
        .clk(clk), .rstn(rstn), .link(wd_link_if_hw_i),
        .wd_active(), .wd_reset_out());

    wd_host wd_host_hw_i (
        .clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata2),
        .avs_waitrequest(), .link(wd_link_if_hw_i));

    wd_link_monitor wd_link_monitor_i (
        .clk(clk), .rstn(rstn), .reg_wr(wd_link_if_i.reg_wr),
        .reg_wdata(wd_link_if_i.reg_wdata),
        .reg_rdata(wd_link_if_i.reg_rdata),
        .stop_instr(wd_link_if_i.stop_instr),
        .irq_req(wd_link_if_i.irq_req), .nmi_req(wd_link_if_i.nmi_req),
        .gen(wd_link_if_i.gen), .core_mode(wd_link_if_i.core_mode),
        .chip_rst(wd_link_if_i.chip_rst));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low.
    task automatic xfer(input logic wr, input logic [3:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q  = avs_readdata;
        q2 = avs_readdata2;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rd_stat();
        xfer(1'b0, `WD_AV_STAT, 32'h0000_0000);
    endtask

    task automatic wr_reg(input logic [7:0] v);
        xfer(1'b1, `WD_AV_CTRL, {16'h0000, v, 8'h01});
    endtask

    task automatic pulse(input int b);
        xfer(1'b1, `WD_AV_CTRL, 32'h0000_0001 << b);
    endtask

    task automatic poll(input logic [7:0] v);
        k = 0;
        do begin
            rd_stat();
            k++;
        end while (q[7:0] !== v && k < 1200);
    endtask

    task automatic wait_rst(input logic lvl);
        k = 0;
        while (wd_link_if_i.chip_rst !== lvl && k < 3300) begin
            @(posedge clk);
            k++;
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    initial begin
        rstn          = 1'b0;
        avs_address   = 4'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0000_0000;
        n_fail        = 0;
        n_checks      = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd_stat();
        chk(q, 32'h0000_01FE, "status after reset");
        chk(q2, 32'h0000_01FF, "hardware option reads active");
        xfer(1'b0, 4'hC, 32'h0000_0000);
        chk(q, 32'h0000_0000, "unmapped read");
        $display("Test reset done");
        // Counter LSB sits in register bit 7; one tick clears it.
        wr_reg(8'h82);
        poll(8'h02);
        chk(q[7:0], 8'h02, "first tick");
        repeat (3000) @(posedge clk);
        rd_stat();
        chk(q[7:0], 8'h02, "no early tick");
        chk(q2[7:0], 8'h83, "control bit write ignored");
        repeat (100) @(posedge clk);
        rd_stat();
        chk(q[11:0], 12'h1FC, "timer wraps through SR");
        $display("Test timer done");
        pulse(`WD_CTL_STOP);
        rd_stat();
        chk(q[10:8], 3'b100, "stop when inactive");
        chk(q2[10:8], 3'b100, "stop freezes with pin high");
        pulse(`WD_CTL_IRQ);
        rd_stat();
        chk(q[10:8], 3'b100, "no wake with gen low");
        xfer(1'b1, `WD_AV_CFG, 32'h0000_0003);
        pulse(`WD_CTL_IRQ);
        rd_stat();
        chk(q[10:8], 3'b001, "wake by interrupt");
        $display("Test stop done");
        wr_reg(8'hFC);
        wait_rst(1'b1);
        chk(k < 4, 1'b1, "software reset prompt");
        chk(wd_reset_out, 1'b1, "reset output");
        wait_rst(1'b0);
        rd_stat();
        chk(q[23:0], 24'h0101FE, "state after reset");
        $display("Test software reset done");
        wr_reg(8'h03);
        repeat (3) @(posedge clk);
        chk(wd_active, 1'b1, "activated");
        xfer(1'b1, `WD_AV_CFG, 32'h0000_0001);
        pulse(`WD_CTL_STOP);
        rd_stat();
        chk(q[10:8], 3'b010, "active stop waits");
        chk(q2[10:8], 3'b010, "stop waits with pin low");
        xfer(1'b1, `WD_AV_CFG, 32'h0000_0003);
        pulse(`WD_CTL_NMI);
        rd_stat();
        chk(q[10:8], 3'b001, "wake by nmi");
        wr_reg(8'h02);
        repeat (3) @(posedge clk);
        rd_stat();
        chk(q[0], 1'b1, "cannot deactivate");
        for (i = 0; i < 27; i++) begin
            pulse(`WD_CTL_INSTR);
        end
        repeat (6300) @(posedge clk);
        rd_stat();
        chk(q[23:16], 8'h01, "guard holds");
        chk(q2[23:16], 8'h01, "guard holds, hardware option");
        pulse(`WD_CTL_INSTR);
        wait_rst(1'b1);
        chk(k > 3040 && k < 3100, 1'b1, "timeout reset");
        rd_stat();
        chk(q[23:16], 8'h02, "reset count");
        wait_rst(1'b0);
        chk(wd_active, 1'b0, "reset deactivates");
        rd_stat();
        chk(q[7:0], 8'hFE, "image after timeout");
        $display("Test timeout done");
        // Let the second pair finish its own timeout reset first.
        repeat (20) @(posedge clk);
        xfer(1'b1, `WD_AV_CFG, 32'h0000_0007);
        wr_reg(8'hFC);
        wait_rst(1'b1);
        wait_rst(1'b0);
        repeat (8) @(posedge clk);
        rd_stat();
        chk(q[11:8], 4'h1, "no forced reset when inactive");
        chk(q2[23:8], 16'h0409, "startup check forces reset");
        $display("Test startup check done");
        wrap_up();
    end

endmodule

`default_nettype wire
